// ### sbd_buffered_port.sv
// buffered-mode flags, two-deep receive buffer and transmit buffer of a serial port
`timescale 1ns/100ps
`include "sbd_regs.svh"

// Operation
// - receive-complete reads high while unread bytes wait, low when buffer empty
// - writing one to receive-complete position also clears it
// - transmit-complete sets when shifting ends with empty buffer; write one clears
// - buffer-empty reads one when transmit buffer empty, zero while byte waits
// - every data register write with byte enable 0 set clears buffer-empty by filling the buffer
// - select trigger sets when master sees select low, forcing slave; write one clears
// - select trigger never sets while select line disable is one
// - overflow sets when third byte completes with both entries full
// - without pending transmit data, overflow waits for next transfer start
// - overflow holds until software reads the data register
// - data register write starts transmission of the written byte
// - data read returns second entry, then first entry moves into second
// - buffer mode enable gives two receive stages, one transmit, separate flags
// - wait option clear: transmit byte waits for one completed transfer
// - in buffer mode each flag except overflow interrupts only with its enable set; overflow never interrupts
module sbd_buffered_port
  import sbd_pkg::*;
(
  input  wire logic             CLK,
  input  wire logic             ARST_N,
  input  wire logic [7:0]       AVS_ADDRESS,
  input  wire logic             AVS_READ,
  input  wire logic             AVS_WRITE,
  input  wire logic [31:0]      AVS_WRITEDATA,
  input  wire logic [3:0]       AVS_BYTEENABLE,
  output logic      [31:0]      AVS_READDATA,
  output logic                  AVS_WAITREQUEST,
  input  wire sbd_link_in_type  LINK_IN,
  output sbd_link_out_type      LINK_OUT,
  output logic                  IRQ
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic          rst_meta;
  logic          rst_n;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------
  sbd_state_type q;
  sbd_state_type next_q;
  logic [5:0]    idx;
  logic          acc;
  logic          wr_any;
  logic          wr_flags;
  logic          wr_data;
  logic          pop;
  logic          done;
  logic          buffered_operation_enable;
  logic          rx_complete_flag;
  logic          trig;
  logic          can_load;
  logic [7:0]    flags_now;
  logic [7:0]    rd_value;

  assign idx      = AVS_ADDRESS[7:2];
  assign acc      = (AVS_READ | AVS_WRITE) & q.ack;
  assign wr_any   = AVS_WRITE & acc & AVS_BYTEENABLE[0];
  assign wr_flags = wr_any & (idx == `SBD_IDX_FLAGS);
  assign wr_data  = wr_any & (idx == `SBD_IDX_DATA);
  assign pop      = AVS_READ & acc & (idx == `SBD_IDX_DATA) & q.rd_pop;
  assign done     = LINK_IN.shift_done;
  assign buffered_operation_enable    = q.ctrl[`SBD_BIT_BUFFERED_OPERATION_ENABLE];
  assign rx_complete_flag    = (q.rx_cnt != 2'h0) & ~q.rxc_hide;
  assign trig     = LINK_IN.master_mode & LINK_IN.ss_low & ~q.ctrl[`SBD_BIT_SSD];
  assign can_load = q.tx_full & ~LINK_IN.shift_busy & ~q.tx_load
                  & (q.ctrl[`SBD_BIT_WAIT_FOR_RECEIVE_OPTION] | q.first_done);

  always_comb begin
    flags_now                 = 8'h00;
    flags_now[`SBD_BIT_RXC]   = rx_complete_flag;
    flags_now[`SBD_BIT_TXC]   = q.txc;
    flags_now[`SBD_BIT_DRE]   = ~q.tx_full;
    flags_now[`SBD_BIT_SSI]   = q.ssi;
    flags_now[`SBD_BIT_OVF]   = q.ovf;
  end

  always_comb begin
    case (idx)
      `SBD_IDX_CTRL:  rd_value = q.ctrl & `SBD_CTRL_MASK;
      `SBD_IDX_IEN:   rd_value = buffered_operation_enable ? (q.ien & `SBD_IEN_MASK) : 8'h00;
      `SBD_IDX_FLAGS: rd_value = flags_now;
      `SBD_IDX_DATA:  rd_value = q.rx_second;
      default:        rd_value = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_q = q;

    // bus: one wait cycle, effects at the edge where waitrequest is low
    next_q.ack = (AVS_READ | AVS_WRITE) & ~q.ack;
    if (AVS_READ & ~q.ack) begin
      next_q.rdata  = {24'h00_0000, rd_value};
      next_q.rd_pop = (idx == `SBD_IDX_DATA) & (q.rx_cnt != 2'h0);
    end

    if (wr_any & (idx == `SBD_IDX_CTRL)) begin
      next_q.ctrl = AVS_WRITEDATA[7:0] & `SBD_CTRL_MASK;
    end
    if (wr_any & (idx == `SBD_IDX_IEN)) begin
      next_q.ien = AVS_WRITEDATA[7:0] & `SBD_IEN_MASK;
    end

    // receive buffer: drain first, then fill
    if (pop) begin
      next_q.rx_second = q.rx_first;
      next_q.rx_cnt    = q.rx_cnt - 2'h1;
      next_q.ovf       = 1'b0;
      next_q.ovf_wait  = 1'b0;
    end
    if (wr_flags & AVS_WRITEDATA[`SBD_BIT_RXC]) begin
      next_q.rxc_hide = 1'b1;
    end
    if (done) begin
      next_q.first_done = 1'b1;
      next_q.rxc_hide   = 1'b0;
      case (next_q.rx_cnt)
        2'h0: begin
          next_q.rx_second = LINK_IN.rx_byte;
          next_q.rx_cnt    = 2'h1;
        end
        2'h1: begin
          next_q.rx_first = LINK_IN.rx_byte;
          next_q.rx_cnt   = `SBD_RX_FULL;
        end
        default: begin
          if (q.tx_full) begin
            next_q.ovf = 1'b1;
          end else begin
            next_q.ovf_wait = 1'b1;
          end
        end
      endcase
    end
    if (q.ovf_wait & LINK_IN.shift_start) begin
      next_q.ovf      = 1'b1;
      next_q.ovf_wait = 1'b0;
    end

    // transmit buffer: shifter takes the byte, then a write may refill
    next_q.tx_load = can_load;
    if (can_load) begin
      next_q.tx_byte = q.tx_data;
      next_q.tx_full = 1'b0;
    end
    if (wr_data) begin
      next_q.tx_data = AVS_WRITEDATA[7:0];
      next_q.tx_full = 1'b1;
    end

    // transmit complete: clear first so a same-cycle event wins
    if (wr_flags & AVS_WRITEDATA[`SBD_BIT_TXC]) begin
      next_q.txc = 1'b0;
    end
    if (done & ~q.tx_full) begin
      next_q.txc = 1'b1;
    end

    // select trigger
    if (wr_flags & AVS_WRITEDATA[`SBD_BIT_SSI]) begin
      next_q.ssi = 1'b0;
    end
    if (trig) begin
      next_q.ssi = 1'b1;
    end
    next_q.force_slave = trig;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      q            <= '0;
      q.ctrl       <= `SBD_CTRL_RST;
      q.ien        <= `SBD_IEN_RST;
      q.tx_data    <= `SBD_DATA_RST;
      q.rx_second  <= `SBD_DATA_RST;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign AVS_WAITREQUEST      = (AVS_READ | AVS_WRITE) & ~q.ack;
  assign AVS_READDATA         = q.rdata;
  assign LINK_OUT.tx_load     = q.tx_load;
  assign LINK_OUT.tx_byte     = q.tx_byte;
  assign LINK_OUT.force_slave = q.force_slave;
  assign LINK_OUT.buf_mode    = buffered_operation_enable;
  assign IRQ = buffered_operation_enable & (|(flags_now & q.ien & `SBD_IEN_MASK));

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  sequence data_write_s;
    wr_data & q.ctrl[`SBD_BIT_WAIT_FOR_RECEIVE_OPTION] & ~q.tx_full & ~q.tx_load;
  endsequence

  sequence shifter_idle_s;
    ~LINK_IN.shift_busy;
  endsequence

  rxc_empty_a: assert property ((q.rx_cnt == 2'h0) |-> !flags_now[`SBD_BIT_RXC])
    else $error("receive-complete high with empty buffer");
  rxc_clear_a: assert property ((wr_flags & AVS_WRITEDATA[`SBD_BIT_RXC] & !done)
    |=> !flags_now[`SBD_BIT_RXC])
    else $error("receive-complete not cleared by write one");
  txc_set_a: assert property ((done & !q.tx_full) |=> q.txc)
    else $error("transmit-complete not set");
  dre_load_a: assert property ((can_load & !wr_data) |=> flags_now[`SBD_BIT_DRE])
    else $error("buffer-empty not set after load");
  dre_write_a: assert property (wr_data |=> !flags_now[`SBD_BIT_DRE])
    else $error("buffer-empty not cleared by data write");
  ssi_set_a: assert property (trig |=> (q.ssi && LINK_OUT.force_slave))
    else $error("select trigger not flagged");
  ssd_block_a: assert property ($rose(q.ssi) |-> !$past(q.ctrl[`SBD_BIT_SSD]))
    else $error("select trigger set while disabled");
  ovf_set_a: assert property ((done & (q.rx_cnt == 2'h2) & !pop & q.tx_full)
    |=> q.ovf)
    else $error("overflow not flagged");
  ovf_wait_a: assert property ((!q.ovf & !q.tx_full & !LINK_IN.shift_start)
    |=> !q.ovf)
    else $error("overflow flagged before transfer start");
  ovf_hold_a: assert property ((q.ovf & !pop) |=> q.ovf)
    else $error("overflow dropped without data read");
  tx_start_a: assert property (data_write_s ##1 shifter_idle_s
    |=> (LINK_OUT.tx_load && (LINK_OUT.tx_byte == $past(AVS_WRITEDATA[7:0], 2))))
    else $error("written byte not handed to shifter");
  rx_shift_a: assert property ((pop & !done & (q.rx_cnt == 2'h2))
    |=> (q.rx_second == $past(q.rx_first)) && (q.rx_cnt == 2'h1))
    else $error("receive entries not advanced on read");
  wait_rx_a: assert property ((!q.first_done & !q.ctrl[`SBD_BIT_WAIT_FOR_RECEIVE_OPTION])
    |-> !next_q.tx_load)
    else $error("byte entered shifter before first transfer");
  irq_gate_a: assert property (!buffered_operation_enable |-> !IRQ)
    else $error("interrupt outside buffer mode");
  irq_rx_a: assert property ((buffered_operation_enable & rx_complete_flag & q.ien[`SBD_BIT_RXC]) |-> IRQ)
    else $error("enabled receive-complete gave no interrupt");

endmodule

// ### sbd_buffered_port_tb.sv
// self-checking bench of the buffered serial port flags and data path
`timescale 1ns/100ps
`include "sbd_regs.svh"
module sbd_buffered_port_tb;
  import sbd_pkg::*;
  localparam int         BITS   = 12;
  localparam logic [7:0] A_CTRL = {`SBD_IDX_CTRL, 2'b00};
  localparam logic [7:0] A_IEN  = {`SBD_IDX_IEN, 2'b00};
  localparam logic [7:0] A_FLG  = {`SBD_IDX_FLAGS, 2'b00};
  localparam logic [7:0] A_DATA = {`SBD_IDX_DATA, 2'b00};
  logic             CLK;
  logic             ARST_N;
  logic [7:0]       addr;
  logic             rd;
  logic             wr;
  logic [31:0]      wdata;
  logic [3:0]       be;
  logic [31:0]      rdata;
  logic             waitreq;
  sbd_link_in_type  link_in;
  sbd_link_out_type link_out;
  logic             irq;
  logic             kick;
  logic [7:0]       rx_value;
  logic             sel_low;
  logic             master;
  logic [7:0]       txq[$];
  int               miscompares;
  int               comparisons;

  sbd_buffered_port DUT (.CLK(CLK), .ARST_N(ARST_N), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .LINK_IN(link_in), .LINK_OUT(link_out), .IRQ(irq));
  sbd_shift_model #(.BITS(BITS)) peer (.clk(CLK), .arst_n(ARST_N), .link_out(link_out), .kick(kick),
    .rx_value(rx_value), .sel_low(sel_low), .master(master), .link_in(link_in));

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // record every byte handed to the shifter
  always @(negedge CLK) begin
    if (link_out.tx_load === 1'b1) txq.push_back(link_out.tx_byte);
  end

  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge CLK);
    addr  <= a;
    wdata <= {24'h0, d};
    rd    <= !w;
    wr    <= w;
    // waitrequest and read data are sampled at the rising edge itself
    do @(posedge CLK); while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask = 8'hFF);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q & {24'h0, mask}, {24'h0, exp & mask});
  endtask

  task automatic rx(input logic [7:0] v);
    @(posedge CLK);
    rx_value <= v;
    kick     <= 1'b1;
    @(posedge CLK);
    kick <= 1'b0;
    repeat (BITS + 3) @(posedge CLK);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd_chk(A_FLG, 8'h20);
    rd_chk(A_DATA, 8'h00);
    rd_chk(A_CTRL, 8'h00);
    rd_chk(8'hFC, 8'h00);
  endtask

  task automatic t_first_transfer;
    wr_reg(A_CTRL, 8'h80);
    wr_reg(A_DATA, 8'h5A);
    repeat (6) @(posedge CLK);
    check(txq.size(), 0);
    rd_chk(A_FLG, 8'h00);
    rx(8'h11);
    rx_value <= 8'h22;
    repeat (BITS + 4) @(posedge CLK);
    check(txq.pop_front(), 8'h5A);
    rd_chk(A_FLG, 8'hE0);
    rd_chk(A_DATA, 8'h11);
    rd_chk(A_DATA, 8'h22);
    rd_chk(A_FLG, 8'h60);
    wr_reg(A_FLG, 8'h40);
    rd_chk(A_FLG, 8'h20);
  endtask

  task automatic t_overflow;
    wr_reg(A_CTRL, 8'hC0);
    rx(8'hA1);
    rx(8'hA2);
    rx(8'hA3);
    rd_chk(A_FLG, 8'h80, 8'h81);
    rx(8'hA4);
    rd_chk(A_FLG, 8'h81, 8'h81);
    rd_chk(A_DATA, 8'hA1);
    rd_chk(A_FLG, 8'h80, 8'h81);
    rd_chk(A_DATA, 8'hA2);
    rd_chk(A_FLG, 8'h00, 8'h81);
    rx(8'hB7);
    wr_reg(A_FLG, 8'h80);
    rd_chk(A_FLG, 8'h00, 8'h80);
    rd_chk(A_DATA, 8'hB7);
  endtask

  task automatic t_select;
    wr_reg(A_CTRL, 8'hC4);
    master  <= 1'b1;
    sel_low <= 1'b1;
    rd_chk(A_FLG, 8'h00, 8'h10);
    check(link_out.force_slave, 1'b0);
    wr_reg(A_CTRL, 8'hC0);
    rd_chk(A_FLG, 8'h10, 8'h10);
    check(link_out.force_slave, 1'b1);
    master  <= 1'b0;
    sel_low <= 1'b0;
    wr_reg(A_FLG, 8'h10);
    rd_chk(A_FLG, 8'h00, 8'h10);
  endtask

  task automatic t_irq;
    wr_reg(A_DATA, 8'h3C);
    repeat (BITS + 4) @(posedge CLK);
    check(txq.pop_front(), 8'h3C);
    wr_reg(A_IEN, 8'h20);
    @(negedge CLK);
    check(irq, 1'b1);
    wr_reg(A_IEN, 8'h10);
    @(negedge CLK);
    check(irq, 1'b0);
    wr_reg(A_IEN, 8'hFF);
    rd_chk(A_IEN, 8'hF0);
    wr_reg(A_CTRL, 8'h00);
    rd_chk(A_IEN, 8'h00);
    check(irq, 1'b0);
  endtask

  task automatic end_of_test;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge CLK);
    miscompares++;
    end_of_test();
  end

  initial begin
    ARST_N   = 1'b0;
    addr     = 8'h00;
    rd       = 1'b0;
    wr       = 1'b0;
    wdata    = 32'h0;
    be       = 4'h1;
    kick     = 1'b0;
    rx_value = 8'h00;
    sel_low  = 1'b0;
    master   = 1'b0;
    repeat (3) @(posedge CLK);
    ARST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    t_reset();
    t_first_transfer();
    t_overflow();
    t_select();
    t_irq();
    end_of_test();
  end
endmodule

// ### sbd_pkg.sv
// types shared by the buffered serial port status and data logic
package sbd_pkg;

  // ----------------------------------------------------------------
  // link toward the shift engine
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       shift_done;
    logic       shift_start;
    logic       shift_busy;
    logic [7:0] rx_byte;
    logic       ss_low;
    logic       master_mode;
  } sbd_link_in_type;

  typedef struct packed {
    logic       tx_load;
    logic [7:0] tx_byte;
    logic       force_slave;
    logic       buf_mode;
  } sbd_link_out_type;

  // ----------------------------------------------------------------
  // complete module state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  ien;
    logic        txc;
    logic        ssi;
    logic        ovf;
    logic        ovf_wait;
    logic        rxc_hide;
    logic        tx_full;
    logic [7:0]  tx_data;
    logic        first_done;
    logic [1:0]  rx_cnt;
    logic [7:0]  rx_first;
    logic [7:0]  rx_second;
    logic        ack;
    logic        rd_pop;
    logic [31:0] rdata;
    logic        tx_load;
    logic [7:0]  tx_byte;
    logic        force_slave;
  } sbd_state_type;

endpackage

// ### sbd_regs.svh
// register offsets, field positions and reset values of the buffered serial port
`ifndef SBD_REGS_SVH
`define SBD_REGS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SBD_IDX_CTRL   6'h01
`define SBD_IDX_IEN    6'h02
`define SBD_IDX_FLAGS  6'h03
`define SBD_IDX_DATA   6'h04

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SBD_BIT_RXC    7
`define SBD_BIT_TXC    6
`define SBD_BIT_DRE    5
`define SBD_BIT_SSI    4
`define SBD_BIT_OVF    0
`define SBD_BIT_BUFFERED_OPERATION_ENABLE  7
`define SBD_BIT_WAIT_FOR_RECEIVE_OPTION  6
`define SBD_BIT_SSD    2

// ----------------------------------------------------------------
// writable masks and reset values
// ----------------------------------------------------------------
`define SBD_CTRL_MASK  8'hC4
`define SBD_IEN_MASK   8'hF0
`define SBD_CTRL_RST   8'h00
`define SBD_IEN_RST    8'h00
`define SBD_DATA_RST   8'h00
`define SBD_RX_FULL    2'h2

`endif

// ### sbd_shift_model.sv
// shift engine model facing the buffered port at its link side
`timescale 1ns/100ps
module sbd_shift_model
  import sbd_pkg::*;
#(
  parameter int BITS = 12
)(
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire sbd_link_out_type link_out,
  input  wire logic             kick,
  input  wire logic [7:0]       rx_value,
  input  wire logic             sel_low,
  input  wire logic             master,
  output sbd_link_in_type       link_in
);
  int   count;
  logic done;
  logic start;
  logic go;

  // a transfer starts on a loaded byte or on a receive-only request
  assign go = (count == 0) && (link_out.tx_load || kick);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 0;
      done  <= 1'b0;
      start <= 1'b0;
    end else begin
      start <= go;
      done  <= (count == 1);
      if (go) begin
        count <= BITS;
      end else if (count != 0) begin
        count <= count - 1;
      end
    end
  end

  assign link_in.shift_done  = done;
  assign link_in.shift_start = start;
  assign link_in.shift_busy  = (count != 0);
  // the byte lines carry no stale copy outside the done pulse
  assign link_in.rx_byte     = done ? rx_value : ~rx_value;
  assign link_in.ss_low      = sel_low;
  assign link_in.master_mode = master;
endmodule
